// File: verilog/mech_src_consts.vh
// Constants for the mechanism parameter source selection block
`ifndef MECH_SRC_CONSTS_VH
`define MECH_SRC_CONSTS_VH

// Source selector codes
`define SRC_SENSOR           1'h0
`define SRC_MANUAL           1'h1

// Rotation direction codes
`define DIR_POS_CCW          1'h0
`define DIR_POS_CW           1'h1

// Reset values
`define RST_MECH_SEL         1'h1
`define RST_GEAR_RATIO       15'h0000
`define RST_WRAP_SEL         1'h0
`define RST_LIMIT_SEL        1'h0
`define RST_PROT_SEL         1'h0
`define RST_INCH_SEL         1'h0
`define RST_ROT_DIR          1'h1
`define RST_WRAP_EN          1'h1
`define RST_WRAP_ZCNT        16'h0001
`define RST_WRAP_RANGE       16'h000a
`define RST_WRAP_RATIO       16'h1388
`define RST_WRAP_OFS         30'h00000000

// Register offsets
`define ADR_SEL              4'h0
`define ADR_GEAR             4'h1
`define ADR_WRAP_CTL         4'h2
`define ADR_WRAP_RANGE       4'h3
`define ADR_WRAP_RATIO       4'h4
`define ADR_WRAP_OFS         4'h5
`define ADR_MECH_MAN         4'h6
`define ADR_LIMIT_MAN        4'h7
`define ADR_PROT_MAN         4'h8
`define ADR_INCH_MAN         4'h9
`define ADR_STATUS           4'ha

// Field positions in the selector register
`define SEL_MECH_BIT         0
`define SEL_WRAP_BIT         1
`define SEL_LIMIT_BIT        2
`define SEL_PROT_BIT         3
`define SEL_INCH_BIT         4
`define SEL_DIR_BIT          5

// Field positions in the wrap control register
`define WCTL_EN_BIT          16
`define WCTL_ZCNT_LSB        0

`endif

// File: verilog/src_mux.v
// Registered two-way source selector for one parameter group
`timescale 1ns/1ps
module src_mux #(
   parameter WIDTH = 32
) (
   input  wire             clock,
   input  wire             reset,
   input  wire             sel_manual,
   input  wire [WIDTH-1:0] sensor_val,
   input  wire [WIDTH-1:0] manual_val,
   output reg  [WIDTH-1:0] eff_ff
);
   always @(posedge clock) begin
      if (reset) begin
         eff_ff <= {WIDTH{1'b0}};
      end else begin
         eff_ff <= sel_manual ? manual_val : sensor_val;
      end
   end
endmodule // src_mux

// File: verilog/mech_param_select.v
// Mechanism parameter source selection: sensor-stored versus manual values
// Summary of operation
// R1: Sensor-stored values take priority over manual ones by default, except the mechanism group, which resets to manual.
// R2: Mechanism selector: 0 sensor, 1 manual; resets to 1.
// R3: Gear ratio 0 loads sensor ratio; 1..32767 sets ratio in 0.01 steps.
// R4: Wrap coordinate selector: 0 sensor, 1 manual; resets to 0.
// R5: Wrap manual values are accepted only while wrap source is manual.
// R6: Limit and protection selectors: 0 follow sensor, 1 ignore; reset 0.
// R7: Inch move and home selector: 0 sensor, 1 manual; resets to 0.
// R8: Host power-cycles the driver after changing the mechanism selector.
// R9: Direction 0 maps positive to counterclockwise, 1 to clockwise; reset 1.
// R10: Each group outputs sensor or manual value per its selector.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "mech_src_consts.vh"
module mech_param_select #(
   parameter MW = 32,
   parameter GW = 15
) (
   input  wire          clock,
   input  wire          reset,
   input  wire [3:0]    addr,
   input  wire [31:0]   wdata,
   input  wire          wr_stb,
   input  wire          rd_stb,
   output reg  [31:0]   rdata_ff,
   input  wire [MW-1:0] sensor_mech,
   input  wire [GW-1:0] sensor_gear,
   input  wire          sensor_wrap_en,
   input  wire [15:0]   sensor_wrap_zcnt,
   input  wire [15:0]   sensor_wrap_range,
   input  wire [15:0]   sensor_wrap_ratio,
   input  wire [29:0]   sensor_wrap_ofs,
   input  wire [MW-1:0] sensor_limit,
   input  wire [MW-1:0] sensor_prot,
   input  wire [MW-1:0] sensor_inch,
   output wire [MW-1:0] eff_mech,
   output wire [GW-1:0] eff_gear,
   output reg           eff_wrap_en_ff,
   output reg  [15:0]   eff_wrap_zcnt_ff,
   output reg  [15:0]   eff_wrap_range_ff,
   output reg  [15:0]   eff_wrap_ratio_ff,
   output reg  [29:0]   eff_wrap_ofs_ff,
   output wire [MW-1:0] eff_limit,
   output wire [MW-1:0] eff_prot,
   output wire [MW-1:0] eff_inch,
   output reg           limit_active_ff,
   output reg           prot_active_ff,
   output reg           pos_is_cw_ff,
   output reg           power_cycle_req_ff
);
   reg          mech_sel_ff;
   reg          wrap_sel_ff;
   reg          limit_sel_ff;
   reg          prot_sel_ff;
   reg          inch_sel_ff;
   reg          rot_dir_ff;
   reg [GW-1:0] gear_ff;
   reg          wrap_en_ff;
   reg [15:0]   wrap_zcnt_ff;
   reg [15:0]   wrap_range_ff;
   reg [15:0]   wrap_ratio_ff;
   reg [29:0]   wrap_ofs_ff;
   reg [MW-1:0] mech_man_ff;
   reg [MW-1:0] limit_man_ff;
   reg [MW-1:0] prot_man_ff;
   reg [MW-1:0] inch_man_ff;
   reg          mech_sel_boot_ff;
   reg [31:0]   nxt_rdata;
   wire         wr_wrap_ok;
   wire         mech_use_manual;

   // Wrap fields only take host writes while the wrap source is manual
   assign wr_wrap_ok = wr_stb && (wrap_sel_ff == `SRC_MANUAL); // see R5

   // Mechanism group follows the selector; the power cycle it needs is only flagged
   assign mech_use_manual = (mech_sel_ff == `SRC_MANUAL); // see R2

   always @(posedge clock) begin
      if (reset) begin
         mech_sel_ff   <= `RST_MECH_SEL; // see R2
         wrap_sel_ff   <= `RST_WRAP_SEL; // see R4
         limit_sel_ff  <= `RST_LIMIT_SEL; // see R6
         prot_sel_ff   <= `RST_PROT_SEL; // see R6
         inch_sel_ff   <= `RST_INCH_SEL; // see R7
         rot_dir_ff    <= `RST_ROT_DIR; // see R9
         gear_ff       <= `RST_GEAR_RATIO; // see R3
         wrap_en_ff    <= `RST_WRAP_EN;
         wrap_zcnt_ff  <= `RST_WRAP_ZCNT;
         wrap_range_ff <= `RST_WRAP_RANGE;
         wrap_ratio_ff <= `RST_WRAP_RATIO;
         wrap_ofs_ff   <= `RST_WRAP_OFS;
         mech_man_ff   <= {MW{1'b0}};
         limit_man_ff  <= {MW{1'b0}};
         prot_man_ff   <= {MW{1'b0}};
         inch_man_ff   <= {MW{1'b0}};
      end else if (wr_stb) begin
         case (addr)
            `ADR_SEL: begin
               mech_sel_ff  <= wdata[`SEL_MECH_BIT];
               wrap_sel_ff  <= wdata[`SEL_WRAP_BIT];
               limit_sel_ff <= wdata[`SEL_LIMIT_BIT];
               prot_sel_ff  <= wdata[`SEL_PROT_BIT];
               inch_sel_ff  <= wdata[`SEL_INCH_BIT];
               rot_dir_ff   <= wdata[`SEL_DIR_BIT];
            end
            `ADR_GEAR: begin
               gear_ff <= wdata[GW-1:0];
            end
            `ADR_WRAP_CTL: begin
               if (wr_wrap_ok) begin // see R5
                  wrap_en_ff   <= wdata[`WCTL_EN_BIT];
                  wrap_zcnt_ff <= wdata[15:0];
               end
            end
            `ADR_WRAP_RANGE: begin
               if (wr_wrap_ok) begin // see R5
                  wrap_range_ff <= wdata[15:0];
               end
            end
            `ADR_WRAP_RATIO: begin
               if (wr_wrap_ok) begin // see R5
                  wrap_ratio_ff <= wdata[15:0];
               end
            end
            `ADR_WRAP_OFS: begin
               if (wr_wrap_ok) begin // see R5
                  wrap_ofs_ff <= wdata[29:0];
               end
            end
            `ADR_MECH_MAN: begin
               mech_man_ff <= wdata[MW-1:0];
            end
            `ADR_LIMIT_MAN: begin
               limit_man_ff <= wdata[MW-1:0];
            end
            `ADR_PROT_MAN: begin
               prot_man_ff <= wdata[MW-1:0];
            end
            `ADR_INCH_MAN: begin
               inch_man_ff <= wdata[MW-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Selector value at reset is kept so a later change raises a power cycle request
   always @(posedge clock) begin
      if (reset) begin
         mech_sel_boot_ff   <= `RST_MECH_SEL; // see R8
         power_cycle_req_ff <= 1'b0;
      end else begin
         power_cycle_req_ff <= (mech_sel_ff != mech_sel_boot_ff); // see R8
      end
   end

   // Effective group values, see R1
   src_mux #(.WIDTH(MW)) u_mech (
      .clock      (clock),
      .reset      (reset),
      .sel_manual (mech_use_manual),
      .sensor_val (sensor_mech),
      .manual_val (mech_man_ff),
      .eff_ff     (eff_mech)
   ); // see R10

   src_mux #(.WIDTH(GW)) u_gear (
      .clock      (clock),
      .reset      (reset),
      .sel_manual (gear_ff != {GW{1'b0}}),
      .sensor_val (sensor_gear),
      .manual_val (gear_ff),
      .eff_ff     (eff_gear)
   ); // see R3

   src_mux #(.WIDTH(MW)) u_limit (
      .clock      (clock),
      .reset      (reset),
      .sel_manual (limit_sel_ff),
      .sensor_val (sensor_limit),
      .manual_val (limit_man_ff),
      .eff_ff     (eff_limit)
   ); // see R6

   src_mux #(.WIDTH(MW)) u_prot (
      .clock      (clock),
      .reset      (reset),
      .sel_manual (prot_sel_ff),
      .sensor_val (sensor_prot),
      .manual_val (prot_man_ff),
      .eff_ff     (eff_prot)
   ); // see R6

   src_mux #(.WIDTH(MW)) u_inch (
      .clock      (clock),
      .reset      (reset),
      .sel_manual (inch_sel_ff),
      .sensor_val (sensor_inch),
      .manual_val (inch_man_ff),
      .eff_ff     (eff_inch)
   ); // see R7

   always @(posedge clock) begin
      if (reset) begin
         eff_wrap_en_ff    <= 1'b0;
         eff_wrap_zcnt_ff  <= 16'h0000;
         eff_wrap_range_ff <= 16'h0000;
         eff_wrap_ratio_ff <= 16'h0000;
         eff_wrap_ofs_ff   <= 30'h00000000;
         limit_active_ff   <= 1'b0;
         prot_active_ff    <= 1'b0;
         pos_is_cw_ff      <= 1'b0;
      end else begin
         if (wrap_sel_ff == `SRC_MANUAL) begin // see R4
            eff_wrap_en_ff    <= wrap_en_ff;
            eff_wrap_zcnt_ff  <= wrap_zcnt_ff;
            eff_wrap_range_ff <= wrap_range_ff;
            eff_wrap_ratio_ff <= wrap_ratio_ff;
            eff_wrap_ofs_ff   <= wrap_ofs_ff;
         end else begin
            eff_wrap_en_ff    <= sensor_wrap_en;
            eff_wrap_zcnt_ff  <= sensor_wrap_zcnt;
            eff_wrap_range_ff <= sensor_wrap_range;
            eff_wrap_ratio_ff <= sensor_wrap_ratio;
            eff_wrap_ofs_ff   <= sensor_wrap_ofs;
         end
         limit_active_ff <= (limit_sel_ff == `SRC_SENSOR); // see R6
         prot_active_ff  <= (prot_sel_ff == `SRC_SENSOR); // see R6
         pos_is_cw_ff    <= (rot_dir_ff == `DIR_POS_CW); // see R9
      end
   end

   always @* begin
      nxt_rdata = 32'h00000000;
      case (addr)
         `ADR_SEL:        nxt_rdata = {26'h0000000, rot_dir_ff, inch_sel_ff, prot_sel_ff,
                                       limit_sel_ff, wrap_sel_ff, mech_sel_ff};
         `ADR_GEAR:       nxt_rdata = {{(32-GW){1'b0}}, gear_ff};
         `ADR_WRAP_CTL:   nxt_rdata = {15'h0000, wrap_en_ff, wrap_zcnt_ff};
         `ADR_WRAP_RANGE: nxt_rdata = {16'h0000, wrap_range_ff};
         `ADR_WRAP_RATIO: nxt_rdata = {16'h0000, wrap_ratio_ff};
         `ADR_WRAP_OFS:   nxt_rdata = {2'h0, wrap_ofs_ff};
         `ADR_MECH_MAN:   nxt_rdata = mech_man_ff;
         `ADR_LIMIT_MAN:  nxt_rdata = limit_man_ff;
         `ADR_PROT_MAN:   nxt_rdata = prot_man_ff;
         `ADR_INCH_MAN:   nxt_rdata = inch_man_ff;
         `ADR_STATUS:     nxt_rdata = {29'h00000000, power_cycle_req_ff,
                                       mech_sel_boot_ff, (gear_ff == {GW{1'b0}})};
         default:         nxt_rdata = 32'h00000000;
      endcase
   end

   always @(posedge clock) begin
      if (reset) begin
         rdata_ff <= 32'h00000000;
      end else if (rd_stb) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 32'h00000000;
      end
   end
endmodule // mech_param_select

// File: tb/sensor_store.sv
// Behavioural model of the sensor memory holding factory group values
`timescale 1ns/1ps
module sensor_store (
   input  wire        clock,
   input  wire        load,
   input  wire [31:0] pat,
   output wire [31:0] mech,
   output wire [14:0] gear,
   output wire        wrap_en,
   output wire [15:0] wrap_zcnt,
   output wire [15:0] wrap_range,
   output wire [15:0] wrap_ratio,
   output wire [29:0] wrap_ofs,
   output wire [31:0] limit,
   output wire [31:0] prot,
   output wire [31:0] inch
);
   reg [31:0] word_ff = 32'h1234_5678;
   // A new part is fitted only when the bench loads one
   always @(posedge clock) begin
      if (load) begin
         word_ff <= pat;
      end
   end
   assign mech       = word_ff;
   assign gear       = word_ff[30:16];
   assign wrap_en    = word_ff[3];
   assign wrap_zcnt  = word_ff[15:0];
   assign wrap_range = word_ff[31:16];
   assign wrap_ratio = ~word_ff[15:0];
   assign wrap_ofs   = word_ff[29:0];
   assign limit      = ~word_ff;
   assign prot       = {word_ff[15:0], word_ff[31:16]};
   assign inch       = word_ff ^ 32'h5a5a_5a5a;
endmodule // sensor_store

// File: tb/mech_src_properties.sv
// Assertions on the source selection block ports
`timescale 1ns/1ps
`include "mech_src_consts.vh"
module mech_src_properties #(
   parameter MW = 32,
   parameter GW = 15
) (
   input wire          clock,
   input wire          reset,
   input wire [3:0]    addr,
   input wire [31:0]   wdata,
   input wire          wr_stb,
   input wire          rd_stb,
   input wire [31:0]   rdata_ff,
   input wire [MW-1:0] sensor_mech,
   input wire [GW-1:0] sensor_gear,
   input wire [15:0]   sensor_wrap_range,
   input wire [MW-1:0] sensor_limit,
   input wire [MW-1:0] sensor_inch,
   input wire [MW-1:0] eff_mech,
   input wire [GW-1:0] eff_gear,
   input wire [15:0]   eff_wrap_range_ff,
   input wire [29:0]   eff_wrap_ofs_ff,
   input wire [MW-1:0] eff_limit,
   input wire [MW-1:0] eff_inch,
   input wire          prot_active_ff,
   input wire          pos_is_cw_ff,
   input wire          power_cycle_req_ff
);
   reg  [1:0]    up_ff;
   reg  [5:0]    sel_ff;
   reg  [GW-1:0] gear_ff;
   reg  [MW-1:0] mech_ff;
   reg  [29:0]   ofs_ff;
   wire          sel_w  = wr_stb && addr == `ADR_SEL;
   wire          gear_w = wr_stb && addr == `ADR_GEAR;
   wire          ok     = up_ff == 2'h3;
   // Shadow of the host-written state; outputs settle two edges after reset
   always @(posedge clock) begin
      if (reset) begin
         up_ff   <= 2'h0;
         sel_ff  <= 6'h21;
         gear_ff <= {GW{1'b0}};
         mech_ff <= {MW{1'b0}};
         ofs_ff  <= 30'h0;
      end else begin
         up_ff <= {up_ff[0], 1'b1};
         if (sel_w) sel_ff <= wdata[5:0];
         if (gear_w) gear_ff <= wdata[GW-1:0];
         if (wr_stb && addr == `ADR_MECH_MAN) mech_ff <= wdata[MW-1:0];
         if (wr_stb && addr == `ADR_WRAP_OFS && sel_ff[1]) ofs_ff <= wdata[29:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence mech_off_write;
      sel_w && !wdata[`SEL_MECH_BIT] ##1 !sel_w;
   endsequence
   sequence gear_write;
      gear_w ##1 !gear_w;
   endsequence
   gear_source_a: assert property (gear_write |=>
      eff_gear == (gear_ff == 0 ? $past(sensor_gear) : gear_ff)) else $error("gear source wrong");
   mech_source_a: assert property (ok |-> eff_mech ==
      ($past(sel_ff[0]) ? $past(mech_ff) : $past(sensor_mech)))
      else $error("mech source wrong");
   power_request_a: assert property (mech_off_write |=> power_cycle_req_ff)
      else $error("no power cycle request");
   wrap_sensor_a: assert property (ok && !$past(sel_ff[1]) |->
      eff_wrap_range_ff == $past(sensor_wrap_range)) else $error("wrap not from sensor");
   wrap_manual_a: assert property (ok && $past(sel_ff[1]) |->
      eff_wrap_ofs_ff == $past(ofs_ff)) else $error("wrap offset not manual");
   limit_sensor_a: assert property (ok && !$past(sel_ff[2]) |->
      eff_limit == $past(sensor_limit)) else $error("limit not from sensor");
   prot_flag_a: assert property (ok |-> prot_active_ff == !$past(sel_ff[3]))
      else $error("protection flag wrong");
   inch_sensor_a: assert property (ok && !$past(sel_ff[4]) |->
      eff_inch == $past(sensor_inch)) else $error("inch not from sensor");
   dir_map_a: assert property (ok |-> pos_is_cw_ff == $past(sel_ff[5]))
      else $error("direction wrong");
   sel_read_a: assert property (rd_stb && addr == `ADR_SEL |=>
      rdata_ff == {26'h0, $past(sel_ff)}) else $error("selector read wrong");
endmodule // mech_src_properties

// File: tb/test_mech_param_select.sv
// Self-checking bench for the mechanism parameter source selection block
`timescale 1ns/1ps
`include "mech_src_consts.vh"
module test_mech_param_select;
   reg          clock = 1'b0;
   reg          reset = 1'b1;
   reg  [3:0]   addr = 4'h0;
   reg  [31:0]  wdata = 32'h0;
   reg          wr_stb = 1'b0;
   reg          rd_stb = 1'b0;
   reg          load = 1'b0;
   reg  [31:0]  pat = 32'h0;
   reg          look = 1'b0;
   reg          rd_d = 1'b0;
   wire [31:0]  rdata_ff, sensor_mech, sensor_limit, sensor_prot, sensor_inch;
   wire [31:0]  eff_mech, eff_limit, eff_prot, eff_inch;
   wire [14:0]  sensor_gear, eff_gear;
   wire [15:0]  sensor_wrap_zcnt, sensor_wrap_range, sensor_wrap_ratio;
   wire [15:0]  eff_wrap_zcnt_ff, eff_wrap_range_ff, eff_wrap_ratio_ff;
   wire [29:0]  sensor_wrap_ofs, eff_wrap_ofs_ff;
   wire         sensor_wrap_en, eff_wrap_en_ff, limit_active_ff, prot_active_ff;
   wire         pos_is_cw_ff, power_cycle_req_ff;
   int          bad_count = 0;
   int          comparisons = 0;
   logic [35:0] notes[$];
   logic [35:0] n;
   logic [31:0] seen;
   logic [31:0] w;
   logic [31:0] rv[12] = '{32'h21, 0, 32'h10001, 32'ha, 32'h1388, 0, 0, 0, 0, 0, 32'h3, 0};
   logic [31:0] gv[3] = '{32'h1, 32'h7fff, 32'h0};
   logic [3:0]  wa[7] = '{4'h7, 4'h8, 4'h9, 4'h5, 4'h3, 4'h2, 4'h4};
   logic [3:0]  wk[7] = '{4'h5, 4'h6, 4'h7, 4'h4, 4'h3, 4'h9, 4'ha};
   logic [31:0] wv[7] = '{32'h11, 32'h22, 32'h33, 32'h3fffffff, 32'h64, 32'h10002, 32'h2710};
   sensor_store model_u (.clock, .load, .pat, .mech(sensor_mech), .gear(sensor_gear),
      .wrap_en(sensor_wrap_en), .wrap_zcnt(sensor_wrap_zcnt), .wrap_range(sensor_wrap_range),
      .wrap_ratio(sensor_wrap_ratio), .wrap_ofs(sensor_wrap_ofs), .limit(sensor_limit),
      .prot(sensor_prot), .inch(sensor_inch));
   mech_param_select dut_u (.clock, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata_ff,
      .sensor_mech, .sensor_gear, .sensor_wrap_en, .sensor_wrap_zcnt, .sensor_wrap_range,
      .sensor_wrap_ratio, .sensor_wrap_ofs, .sensor_limit, .sensor_prot, .sensor_inch,
      .eff_mech, .eff_gear, .eff_wrap_en_ff, .eff_wrap_zcnt_ff, .eff_wrap_range_ff,
      .eff_wrap_ratio_ff, .eff_wrap_ofs_ff, .eff_limit, .eff_prot, .eff_inch,
      .limit_active_ff, .prot_active_ff, .pos_is_cw_ff, .power_cycle_req_ff);
   initial begin
      forever #4 clock = ~clock;
   end
   task automatic check(input logic [3:0] k, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD out%0d expected %h seen %h", k, exp, got);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      notes.push_back({4'h0, e});
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic eff(input logic [3:0] k, input logic [31:0] e);
      repeat (2) @(posedge clock);
      notes.push_back({k, e});
      look <= 1'b1;
      @(posedge clock);
      look <= 1'b0;
      @(posedge clock);
   endtask
   // Each result on the outputs is matched against the oldest pending note
   always @(posedge clock) begin
      if (look || rd_d) begin
         if (notes.size() == 0) begin
            check(4'hf, 32'h1, 32'h0);
         end else begin
            n = notes.pop_front();
            case (n[35:32])
               4'h0: seen = rdata_ff;
               4'h1: seen = eff_mech;
               4'h2: seen = {17'h0, eff_gear};
               4'h3: seen = {16'h0, eff_wrap_range_ff};
               4'h4: seen = {2'h0, eff_wrap_ofs_ff};
               4'h5: seen = eff_limit;
               4'h6: seen = eff_prot;
               4'h7: seen = eff_inch;
               4'h9: seen = {15'h0, eff_wrap_en_ff, eff_wrap_zcnt_ff};
               4'ha: seen = {16'h0, eff_wrap_ratio_ff};
               default: seen = {28'h0, power_cycle_req_ff, prot_active_ff,
                  limit_active_ff, pos_is_cw_ff};
            endcase
            check(n[35:32], seen, n[31:0]);
         end
      end
      rd_d <= rd_stb;
   end
   initial begin
      void'($urandom(32'hb3c4ba30));
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 12; i++) begin
         rd(i[3:0], rv[i]);
      end
      eff(4'h8, 32'h7);
      for (int i = 0; i < 3; i++) begin
         w = $urandom();
         pat <= $urandom();
         load <= 1'b1;
         wr(`ADR_MECH_MAN, w);
         load <= 1'b0;
         wr(`ADR_WRAP_RANGE, w);
         eff(4'h1, w);
         eff(4'h3, {16'h0, sensor_wrap_range});
         eff(4'h5, sensor_limit);
         eff(4'h6, sensor_prot);
         eff(4'h4, {2'h0, sensor_wrap_ofs});
         eff(4'h7, sensor_inch);
      end
      rd(`ADR_WRAP_RANGE, 32'ha);
      for (int i = 0; i < 3; i++) begin
         wr(`ADR_GEAR, gv[i]);
         eff(4'h2, gv[i] == 0 ? {17'h0, sensor_gear} : gv[i]);
      end
      wr(`ADR_SEL, 32'h1e);
      eff(4'h1, sensor_mech);
      for (int i = 0; i < 7; i++) begin
         wr(wa[i], wv[i]);
         eff(wk[i], wv[i]);
      end
      eff(4'h8, 32'h8);
      reset <= 1'b1;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rd(`ADR_SEL, 32'h21);
      eff(4'h8, 32'h7);
      eff(4'h1, 32'h0);
      repeat (3) @(posedge clock);
      check(4'hf, notes.size(), 32'h0);
      close_out;
   end
endmodule // test_mech_param_select
bind mech_param_select mech_src_properties #(.MW(MW), .GW(GW)) props_u (.clock, .reset,
   .addr, .wdata, .wr_stb, .rd_stb, .rdata_ff, .sensor_mech, .sensor_gear, .sensor_wrap_range,
   .sensor_limit, .sensor_inch, .eff_mech, .eff_gear, .eff_wrap_range_ff, .eff_wrap_ofs_ff,
   .eff_limit, .eff_inch, .prot_active_ff, .pos_is_cw_ff, .power_cycle_req_ff);
